// *** rtl/eap_pins.sv ***
// pin-role logic, serial engine, tx fifo and ahb-lite registers of the second audio port
//
// Added by the designer: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "eap_params.svh"

// ----------------------------------------------------------------
// tx fifo
// ----------------------------------------------------------------
module eap_fifo #(
	parameter int WIDTH = `EAP_FIFO_WIDTH,
	parameter int DEPTH = `EAP_FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] rd_ptr_reg;
	logic do_push;
	logic do_pop;

	assign in_ready = (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]) || (wr_ptr_reg[AW] == rd_ptr_reg[AW]);
	assign out_valid = (wr_ptr_reg != rd_ptr_reg);
	assign out_data = mem_reg[rd_ptr_reg[AW-1:0]];
	assign do_push = in_valid && in_ready;
	assign do_pop = out_valid && out_ready;

	always_ff @(posedge clk_sys)
	begin
		if (do_push)
		begin
			mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end
		else
		begin
			if (do_push)
			begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (do_pop)
			begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end
endmodule

// Operation
// - async mode: rx sync pin frames receivers
// - sync mode: rx sync is flag1 or buffer enable
// - flag1 direction follows rx_sync_direction
// - output flag1 updates at frame or slot
// - input flag1 captured at frame or slot
// - rx clock pin: receiver clock, or flag0
// - flag0 direction follows rx_clock_direction
// - output flag0 updates at frame or slot
// - input flag0 captured at frame or slot
// - tx sync frames tx, plus rx when synchronous
// - tx sync direction follows tx_sync_direction
// - tx clock clocks tx, plus rx when synchronous
// - data pin a: shifter five out, zero in
// - data pin b: shifter four out, one in
// - gpio per pin; reset leaves all disconnected
module eap_pins (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic port_pin_rx_clock_in,
	output logic port_pin_rx_clock_out,
	output logic port_pin_rx_clock_oe,
	input wire logic port_pin_rx_sync_in,
	output logic port_pin_rx_sync_out,
	output logic port_pin_rx_sync_oe,
	input wire logic port_pin_tx_clock_in,
	output logic port_pin_tx_clock_out,
	output logic port_pin_tx_clock_oe,
	input wire logic port_pin_tx_sync_in,
	output logic port_pin_tx_sync_out,
	output logic port_pin_tx_sync_oe,
	input wire logic port_pin_data_a_in,
	output logic port_pin_data_a_out,
	output logic port_pin_data_a_oe,
	input wire logic port_pin_data_b_in,
	output logic port_pin_data_b_out,
	output logic port_pin_data_b_oe
);
	import eap_pkg::*;

	function automatic logic gpio_drives(input logic [1:0] mode);
		gpio_drives = (mode == EAP_GPIO_OUT);
	endfunction

	function automatic logic gpio_listens(input logic [1:0] mode);
		gpio_listens = (mode == EAP_GPIO_IN);
	endfunction

	// ----------------------------------------------------------------
	// registers and decoded controls
	// ----------------------------------------------------------------
	logic [31:0] ctrl_reg;
	logic [31:0] rxck_reg;
	logic [31:0] txck_reg;
	logic [31:0] gdir_reg;
	logic [31:0] gout_reg;
	logic synchronous_mode_select;
	logic tx_buffer_enable_select;
	logic network_mode;
	logic port_enable;
	logic tx_enable;
	logic rx_enable;
	logic rx_clock_direction;
	logic rx_sync_direction;
	logic tx_clock_direction;
	logic tx_sync_direction;

	assign synchronous_mode_select = ctrl_reg[`EAP_CTRL_SYNC];
	assign tx_buffer_enable_select = ctrl_reg[`EAP_CTRL_BUFE];
	assign network_mode = ctrl_reg[`EAP_CTRL_NET];
	assign port_enable = ctrl_reg[`EAP_CTRL_PORT_EN];
	assign tx_enable = ctrl_reg[`EAP_CTRL_TX_EN];
	assign rx_enable = ctrl_reg[`EAP_CTRL_RX_EN];
	assign rx_clock_direction = rxck_reg[`EAP_CCR_CKD];
	assign rx_sync_direction = rxck_reg[`EAP_CCR_FSD];
	assign tx_clock_direction = txck_reg[`EAP_CCR_CKD];
	assign tx_sync_direction = txck_reg[`EAP_CCR_FSD];

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [`EAP_NPINS-1:0] pin_in;
	logic [`EAP_NPINS-1:0] meta_reg;
	logic [`EAP_NPINS-1:0] sync_reg;

	assign pin_in = {port_pin_data_b_in, port_pin_data_a_in, port_pin_tx_sync_in,
		port_pin_tx_clock_in, port_pin_rx_sync_in, port_pin_rx_clock_in};

	// meta_reg is read only by sync_reg
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
		end
		else
		begin
			meta_reg <= pin_in;
			sync_reg <= meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// bit clock dividers: index 0 receiver, 1 transmitter
	// ----------------------------------------------------------------
	logic [7:0] div_cnt_reg [2];
	logic gen_clk_reg [2];
	logic [7:0] div_val [2];
	logic div_run [2];

	assign div_val[0] = rxck_reg[`EAP_CCR_DIV_MSB:`EAP_CCR_DIV_LSB];
	assign div_val[1] = txck_reg[`EAP_CCR_DIV_MSB:`EAP_CCR_DIV_LSB];
	assign div_run[0] = rx_enable && !synchronous_mode_select;
	assign div_run[1] = tx_enable;

	generate
		for (genvar d = 0; d < 2; d++)
		begin : g_div
			always_ff @(posedge clk_sys or negedge reset_n)
			begin
				if (!reset_n)
				begin
					div_cnt_reg[d] <= 8'h00;
					gen_clk_reg[d] <= 1'b0;
				end
				else if (!div_run[d])
				begin
					div_cnt_reg[d] <= 8'h00;
					gen_clk_reg[d] <= 1'b0;
				end
				else if (div_cnt_reg[d] >= div_val[d])
				begin
					div_cnt_reg[d] <= 8'h00;
					gen_clk_reg[d] <= !gen_clk_reg[d];
				end
				else
				begin
					div_cnt_reg[d] <= div_cnt_reg[d] + 8'h01;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// bit clock edges
	// ----------------------------------------------------------------
	logic tx_clk_now;
	logic rx_clk_now;
	logic tx_clk_prev_reg;
	logic rx_clk_prev_reg;
	logic tx_rise;
	logic rx_rise;

	// external clocks are only seen after synchronising; limits link rate to about clk/4
	assign tx_clk_now = tx_clock_direction ? gen_clk_reg[1] : sync_reg[`EAP_PIN_TXC];
	assign rx_clk_now = rx_clock_direction ? gen_clk_reg[0] : sync_reg[`EAP_PIN_RXC];
	assign tx_rise = tx_clk_now && !tx_clk_prev_reg;
	assign rx_rise = rx_clk_now && !rx_clk_prev_reg;

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tx_clk_prev_reg <= 1'b0;
			rx_clk_prev_reg <= 1'b0;
		end
		else
		begin
			tx_clk_prev_reg <= tx_clk_now;
			rx_clk_prev_reg <= rx_clk_now;
		end
	end

	// ----------------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------------
	logic [4:0] tx_cnt_reg;
	logic [4:0] tx_cnt_next;
	logic [15:0] tx_shift_five_reg;
	logic [15:0] tx_shift_four_reg;
	logic tx_step;
	logic tx_slot_start;
	logic tx_frame_start;
	logic tx_fs_ext;
	logic tx_fs_int;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [31:0] fifo_out_data;

	assign tx_fs_ext = !tx_sync_direction && sync_reg[`EAP_PIN_TXS];
	assign tx_fs_int = tx_sync_direction && tx_enable && (tx_cnt_reg == 5'h00);
	assign tx_cnt_next = (tx_fs_ext || tx_cnt_reg == `EAP_FRAME_LAST) ? 5'h00 : tx_cnt_reg + 5'h01;
	assign tx_step = tx_rise && tx_enable;
	assign tx_slot_start = tx_step && (tx_cnt_next[3:0] == 4'h0);
	assign tx_frame_start = tx_step && (tx_cnt_next == 5'h00);

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tx_cnt_reg <= `EAP_FRAME_LAST;
			tx_shift_five_reg <= 16'h0000;
			tx_shift_four_reg <= 16'h0000;
		end
		else if (tx_step)
		begin
			tx_cnt_reg <= tx_cnt_next;
			if (tx_slot_start)
			begin
				// an empty fifo sends silence rather than stale data
				tx_shift_five_reg <= fifo_out_valid ? fifo_out_data[15:0] : 16'h0000;
				tx_shift_four_reg <= fifo_out_valid ? fifo_out_data[31:16] : 16'h0000;
			end
			else
			begin
				tx_shift_five_reg <= {tx_shift_five_reg[14:0], 1'b0};
				tx_shift_four_reg <= {tx_shift_four_reg[14:0], 1'b0};
			end
		end
	end

	eap_fifo #(.WIDTH(`EAP_FIFO_WIDTH), .DEPTH(`EAP_FIFO_DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(hwdata),
		.out_valid(fifo_out_valid),
		.out_ready(tx_slot_start),
		.out_data(fifo_out_data)
	);

	// ----------------------------------------------------------------
	// receiver
	// ----------------------------------------------------------------
	logic [4:0] rx_cnt_reg;
	logic [4:0] rx_pos;
	logic [15:0] rx_shift_zero_reg;
	logic [15:0] rx_shift_one_reg;
	logic [15:0] rx_zero_next;
	logic [15:0] rx_one_next;
	logic [31:0] rx_data_reg;
	logic rx_valid_reg;
	logic rx_edge;
	logic rx_fs;
	logic rx_step;
	logic rx_word_done;
	logic rx_data_read;
	logic a_is_tx;
	logic b_is_tx;

	assign a_is_tx = ctrl_reg[`EAP_CTRL_A_TX];
	assign b_is_tx = ctrl_reg[`EAP_CTRL_B_TX];
	assign rx_edge = synchronous_mode_select ? tx_rise : rx_rise;
	always_comb
	begin
		if (synchronous_mode_select)
		begin
			rx_fs = tx_sync_direction ? (tx_cnt_reg == 5'h00) : sync_reg[`EAP_PIN_TXS];
		end
		else
		begin
			rx_fs = rx_sync_direction ? (rx_cnt_reg == 5'h00) : sync_reg[`EAP_PIN_RXS];
		end
	end
	assign rx_step = rx_edge && rx_enable;
	assign rx_pos = rx_fs ? 5'h00 : rx_cnt_reg;
	assign rx_word_done = rx_step && (rx_pos[3:0] == `EAP_SLOT_LAST);
	assign rx_zero_next = {rx_shift_zero_reg[14:0], !a_is_tx && sync_reg[`EAP_PIN_DA]};
	assign rx_one_next = {rx_shift_one_reg[14:0], !b_is_tx && sync_reg[`EAP_PIN_DB]};

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rx_cnt_reg <= 5'h00;
			rx_shift_zero_reg <= 16'h0000;
			rx_shift_one_reg <= 16'h0000;
			rx_data_reg <= `EAP_RESET_WORD;
		end
		else if (rx_step)
		begin
			rx_cnt_reg <= rx_pos + 5'h01;
			rx_shift_zero_reg <= rx_zero_next;
			rx_shift_one_reg <= rx_one_next;
			if (rx_word_done)
			begin
				rx_data_reg <= {rx_one_next, rx_zero_next};
			end
		end
	end

	// a new word wins over a read that clears the flag in the same cycle
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rx_valid_reg <= 1'b0;
		end
		else if (rx_word_done)
		begin
			rx_valid_reg <= 1'b1;
		end
		else if (rx_data_read)
		begin
			rx_valid_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// serial flags, aligned to frame or slot
	// ----------------------------------------------------------------
	logic flag_align;
	logic oflag0_reg;
	logic oflag1_reg;
	logic iflag0_reg;
	logic iflag1_reg;

	assign flag_align = synchronous_mode_select && (network_mode ? tx_slot_start : tx_frame_start);

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			oflag0_reg <= 1'b0;
			oflag1_reg <= 1'b0;
			iflag0_reg <= 1'b0;
			iflag1_reg <= 1'b0;
		end
		else if (flag_align)
		begin
			oflag0_reg <= ctrl_reg[`EAP_CTRL_OFLAG0];
			oflag1_reg <= ctrl_reg[`EAP_CTRL_OFLAG1];
			if (!rx_clock_direction)
			begin
				iflag0_reg <= sync_reg[`EAP_PIN_RXC];
			end
			if (!rx_sync_direction && !tx_buffer_enable_select)
			begin
				iflag1_reg <= sync_reg[`EAP_PIN_RXS];
			end
		end
	end

	// ----------------------------------------------------------------
	// pin roles
	// ----------------------------------------------------------------
	logic [`EAP_NPINS-1:0] pin_out_next;
	logic [`EAP_NPINS-1:0] pin_oe_next;
	logic [`EAP_NPINS-1:0] pin_out_reg;
	logic [`EAP_NPINS-1:0] pin_oe_reg;
	logic [`EAP_NPINS-1:0] gpio_drv;
	logic [`EAP_NPINS-1:0] gpio_in_val;

	generate
		for (genvar p = 0; p < `EAP_NPINS; p++)
		begin : g_gpio
			assign gpio_drv[p] = gpio_drives(gdir_reg[2*p+1:2*p]);
			assign gpio_in_val[p] = gpio_listens(gdir_reg[2*p+1:2*p]) && sync_reg[p];
		end
	endgenerate

	always_comb
	begin
		if (!port_enable)
		begin
			pin_out_next = gout_reg[`EAP_NPINS-1:0];
			pin_oe_next = gpio_drv;
		end
		else
		begin
			pin_oe_next[`EAP_PIN_RXC] = rx_clock_direction;
			pin_out_next[`EAP_PIN_RXC] = synchronous_mode_select ? oflag0_reg : gen_clk_reg[0];
			pin_oe_next[`EAP_PIN_RXS] = rx_sync_direction;
			if (!synchronous_mode_select)
			begin
				pin_out_next[`EAP_PIN_RXS] = rx_enable && (rx_cnt_reg == 5'h00);
			end
			else if (tx_buffer_enable_select)
			begin
				pin_out_next[`EAP_PIN_RXS] = tx_enable;
			end
			else
			begin
				pin_out_next[`EAP_PIN_RXS] = oflag1_reg;
			end
			pin_oe_next[`EAP_PIN_TXC] = tx_clock_direction;
			pin_out_next[`EAP_PIN_TXC] = gen_clk_reg[1];
			pin_oe_next[`EAP_PIN_TXS] = tx_sync_direction;
			pin_out_next[`EAP_PIN_TXS] = tx_fs_int;
			pin_oe_next[`EAP_PIN_DA] = a_is_tx && tx_enable;
			pin_out_next[`EAP_PIN_DA] = tx_shift_five_reg[15];
			pin_oe_next[`EAP_PIN_DB] = b_is_tx && tx_enable;
			pin_out_next[`EAP_PIN_DB] = tx_shift_four_reg[15];
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pin_out_reg <= '0;
			pin_oe_reg <= '0;
		end
		else
		begin
			pin_out_reg <= pin_out_next;
			pin_oe_reg <= pin_oe_next;
		end
	end

	assign port_pin_rx_clock_out = pin_out_reg[`EAP_PIN_RXC];
	assign port_pin_rx_clock_oe = pin_oe_reg[`EAP_PIN_RXC];
	assign port_pin_rx_sync_out = pin_out_reg[`EAP_PIN_RXS];
	assign port_pin_rx_sync_oe = pin_oe_reg[`EAP_PIN_RXS];
	assign port_pin_tx_clock_out = pin_out_reg[`EAP_PIN_TXC];
	assign port_pin_tx_clock_oe = pin_oe_reg[`EAP_PIN_TXC];
	assign port_pin_tx_sync_out = pin_out_reg[`EAP_PIN_TXS];
	assign port_pin_tx_sync_oe = pin_oe_reg[`EAP_PIN_TXS];
	assign port_pin_data_a_out = pin_out_reg[`EAP_PIN_DA];
	assign port_pin_data_a_oe = pin_oe_reg[`EAP_PIN_DA];
	assign port_pin_data_b_out = pin_out_reg[`EAP_PIN_DB];
	assign port_pin_data_b_oe = pin_oe_reg[`EAP_PIN_DB];

	// ----------------------------------------------------------------
	// ahb-lite slave, one wait state (more for a write to a full fifo) so read data is never stale
	// ----------------------------------------------------------------
	eap_bus_state_t bus_state_reg;
	logic d_write_reg;
	logic [7:0] d_addr_reg;
	logic [31:0] hrdata_reg;
	logic hreadyout_reg;
	logic [31:0] status_word;
	logic [31:0] read_word;
	logic d_done;

	assign hrdata = hrdata_reg;
	assign hreadyout = hreadyout_reg;
	assign hresp = 1'b0;
	assign fifo_in_valid = (bus_state_reg == EAP_BUS_DATA) && d_write_reg && (d_addr_reg == `EAP_OFS_TXDATA);
	// a full fifo stalls the bus until a slot drains a word
	assign d_done = !fifo_in_valid || fifo_in_ready;
	assign rx_data_read = (bus_state_reg == EAP_BUS_DATA) && !d_write_reg && (d_addr_reg == `EAP_OFS_RXDATA);

	always_comb
	begin
		status_word = 32'h00000000;
		status_word[`EAP_STAT_IFLAG0] = iflag0_reg;
		status_word[`EAP_STAT_IFLAG1] = iflag1_reg;
		status_word[`EAP_STAT_FULL] = !fifo_in_ready;
		status_word[`EAP_STAT_RXV] = rx_valid_reg;
		case (d_addr_reg)
			`EAP_OFS_CTRL: read_word = ctrl_reg;
			`EAP_OFS_RXCK: read_word = rxck_reg;
			`EAP_OFS_TXCK: read_word = txck_reg;
			`EAP_OFS_STAT: read_word = status_word;
			`EAP_OFS_RXDATA: read_word = rx_data_reg;
			`EAP_OFS_GDIR: read_word = gdir_reg;
			`EAP_OFS_GOUT: read_word = gout_reg;
			`EAP_OFS_GIN: read_word = {26'h0000000, gpio_in_val};
			default: read_word = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bus_state_reg <= EAP_BUS_IDLE;
			d_write_reg <= 1'b0;
			d_addr_reg <= 8'h00;
			hrdata_reg <= `EAP_RESET_WORD;
			hreadyout_reg <= 1'b1;
		end
		else
		begin
			case (bus_state_reg)
				EAP_BUS_IDLE:
				begin
					if (hsel && htrans[1] && hready)
					begin
						bus_state_reg <= EAP_BUS_DATA;
						d_write_reg <= hwrite;
						d_addr_reg <= {haddr[7:2], 2'b00};
						hreadyout_reg <= 1'b0;
					end
				end
				EAP_BUS_DATA:
				begin
					if (d_done)
					begin
						bus_state_reg <= EAP_BUS_IDLE;
						hreadyout_reg <= 1'b1;
						if (!d_write_reg)
						begin
							hrdata_reg <= read_word;
						end
					end
				end
				default:
				begin
					bus_state_reg <= EAP_BUS_IDLE;
					hreadyout_reg <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ctrl_reg <= `EAP_RESET_WORD;
			rxck_reg <= `EAP_RESET_WORD;
			txck_reg <= `EAP_RESET_WORD;
			gdir_reg <= `EAP_RESET_WORD;
			gout_reg <= `EAP_RESET_WORD;
		end
		else if ((bus_state_reg == EAP_BUS_DATA) && d_write_reg)
		begin
			case (d_addr_reg)
				`EAP_OFS_CTRL: ctrl_reg <= hwdata & `EAP_CTRL_MASK;
				`EAP_OFS_RXCK: rxck_reg <= hwdata & `EAP_CCR_MASK;
				`EAP_OFS_TXCK: txck_reg <= hwdata & `EAP_CCR_MASK;
				`EAP_OFS_GDIR: gdir_reg <= hwdata & `EAP_GDIR_MASK;
				`EAP_OFS_GOUT: gout_reg <= hwdata & `EAP_GOUT_MASK;
				default: ctrl_reg <= ctrl_reg;
			endcase
		end
	end
endmodule

// *** include/eap_params.svh ***
// offsets, field positions, reset values and counts of the serial audio pin block
`ifndef EAP_PARAMS_SVH
`define EAP_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define EAP_OFS_CTRL 8'h00
`define EAP_OFS_RXCK 8'h04
`define EAP_OFS_TXCK 8'h08
`define EAP_OFS_STAT 8'h0C
`define EAP_OFS_TXDATA 8'h10
`define EAP_OFS_RXDATA 8'h14
`define EAP_OFS_GDIR 8'h18
`define EAP_OFS_GOUT 8'h1C
`define EAP_OFS_GIN 8'h20

// ----------------------------------------------------------------
// common_control_register fields
// ----------------------------------------------------------------
`define EAP_CTRL_SYNC 0
`define EAP_CTRL_BUFE 1
`define EAP_CTRL_NET 2
`define EAP_CTRL_PORT_EN 3
`define EAP_CTRL_OFLAG0 4
`define EAP_CTRL_OFLAG1 5
`define EAP_CTRL_A_TX 6
`define EAP_CTRL_B_TX 7
`define EAP_CTRL_TX_EN 8
`define EAP_CTRL_RX_EN 9
`define EAP_CTRL_MASK 32'h000003FF

// ----------------------------------------------------------------
// clock control fields, shared by receiver and transmitter
// ----------------------------------------------------------------
`define EAP_CCR_CKD 0
`define EAP_CCR_FSD 1
`define EAP_CCR_DIV_LSB 8
`define EAP_CCR_DIV_MSB 15
`define EAP_CCR_MASK 32'h0000FF03

// ----------------------------------------------------------------
// common_status_register fields
// ----------------------------------------------------------------
`define EAP_STAT_IFLAG0 0
`define EAP_STAT_IFLAG1 1
`define EAP_STAT_FULL 2
`define EAP_STAT_RXV 3

// ----------------------------------------------------------------
// reset values, framing and sizes
// ----------------------------------------------------------------
`define EAP_RESET_WORD 32'h00000000
`define EAP_GDIR_MASK 32'h00000FFF
`define EAP_GOUT_MASK 32'h0000003F
`define EAP_FRAME_LAST 5'h1F
`define EAP_SLOT_LAST 4'hF
`define EAP_FIFO_DEPTH 8
`define EAP_FIFO_WIDTH 32
`define EAP_NPINS 6

// pin indices
`define EAP_PIN_RXC 0
`define EAP_PIN_RXS 1
`define EAP_PIN_TXC 2
`define EAP_PIN_TXS 3
`define EAP_PIN_DA 4
`define EAP_PIN_DB 5

`endif

// *** include/eap_pkg.sv ***
// types of the serial audio pin block
package eap_pkg;

	typedef enum logic [0:0]
	{
		EAP_BUS_IDLE = 1'b0,
		EAP_BUS_DATA = 1'b1
	} eap_bus_state_t;

	typedef enum logic [1:0]
	{
		EAP_GPIO_OFF = 2'b00,
		EAP_GPIO_IN = 2'b01,
		EAP_GPIO_OUT = 2'b11
	} eap_gpio_mode_t;

endpackage

// *** test/eap_pins_assertions.sv ***
// port checks of the audio pin block
`timescale 1ns/1ps
module eap_chk (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic port_pin_rx_clock_oe,
	input wire logic port_pin_rx_sync_oe,
	input wire logic port_pin_tx_clock_oe,
	input wire logic port_pin_tx_sync_oe
);
	// ----------------------------------------------------------------
	// bus handshake and pin direction
	// ----------------------------------------------------------------
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	sequence s_taken;
		hsel && htrans[1] && hready && hreadyout;
	endsequence
	sequence s_one_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	chk_taken_waits: assert property (s_taken |=> !hreadyout)
		else $error("no wait state after address");
	chk_read_one_wait: assert property (s_taken ##0 !hwrite |=> s_one_wait)
		else $error("read wait not one cycle");
	chk_wait_bounded: assert property ($fell(hreadyout) |-> ##[1:1000] hreadyout)
		else $error("wait state never ends");
	chk_wait_cause: assert property ($fell(hreadyout) |-> $past(hsel) && $past(htrans[1]) && $past(hready))
		else $error("wait without address");
	chk_rdata_holds: assert property ($changed(hrdata) |-> $rose(hreadyout))
		else $error("read data moved outside completion");
	chk_resp_okay: assert property (!hresp)
		else $error("response not okay");
	chk_reset_pins: assert property ($rose(reset_n) |-> !(port_pin_rx_clock_oe ||
		port_pin_rx_sync_oe || port_pin_tx_clock_oe || port_pin_tx_sync_oe))
		else $error("pin driven out of reset");
	// directions only follow register writes, never the link itself
	chk_dir_by_write: assert property ($changed({port_pin_rx_clock_oe, port_pin_rx_sync_oe,
		port_pin_tx_clock_oe, port_pin_tx_sync_oe}) |-> !$past(hreadyout) || !$past(hreadyout, 2))
		else $error("direction moved without write");
endmodule

bind eap_pins eap_chk u_chk (.clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.port_pin_rx_clock_oe(port_pin_rx_clock_oe), .port_pin_rx_sync_oe(port_pin_rx_sync_oe),
	.port_pin_tx_clock_oe(port_pin_tx_clock_oe), .port_pin_tx_sync_oe(port_pin_tx_sync_oe));

// *** test/eap_codec.sv ***
// far-side codec: bit clock, frame sync, two data lines
`timescale 1ns/1ps
module eap_codec (
	input wire logic run,
	input wire logic [15:0] send_a,
	input wire logic [15:0] send_b,
	input wire logic line_a,
	input wire logic line_b,
	output logic bclk,
	output logic fsync,
	output logic sd_a,
	output logic sd_b,
	output logic [15:0] got_a,
	output logic [15:0] got_b
);
	int bitn = 0;
	logic [15:0] sh_a = 16'h0000;
	logic [15:0] sh_b = 16'h0000;
	initial
	begin
		{bclk, fsync, sd_a, sd_b} = 4'h0;
		{got_a, got_b} = 32'h00000000;
	end
	// clock stands low between runs
	always
	begin
		#100;
		bclk = run ? !bclk : 1'b0;
	end
	// launch on fall so the device sees settled data at the rise
	always @(negedge bclk)
	begin
		fsync = (bitn == 0);
		sd_a = send_a[15 - bitn % 16];
		sd_b = send_b[15 - bitn % 16];
	end
	// device launches after a rise; taken at the next rise
	always @(posedge bclk)
	begin
		sh_a = {sh_a[14:0], line_a};
		sh_b = {sh_b[14:0], line_b};
		if (bitn % 16 == 0)
			{got_b, got_a} = {sh_b, sh_a};
		bitn = (bitn + 1) % 32;
	end
endmodule

// *** test/eap_pins_test.sv ***
// self-checking bench of the audio pin block
`timescale 1ns/1ps
`include "eap_params.svh"
module eap_pins_test;
	import eap_pkg::*;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] hrdata, q, w;
	logic hreadyout, hresp, run = 1'b0;
	logic [5:0] po, pe, pl, pd = 6'h00;
	logic [15:0] snd_a = 16'h0000, snd_b = 16'h0000, got_a, got_b;
	logic bclk, fsync, sd_a, sd_b;
	integer seed = 32'h95E8B3C5;
	int failures = 0;
	int checks = 0;
	always #12.5 clk_sys = ~clk_sys;
	assign pl = (pe & po) | (~pe & (run ? {sd_b, sd_a, fsync, bclk, pd[1:0]} : pd));
	eap_pins dut (.clk_sys(clk_sys), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.port_pin_rx_clock_in(pl[0]), .port_pin_rx_clock_out(po[0]), .port_pin_rx_clock_oe(pe[0]),
		.port_pin_rx_sync_in(pl[1]), .port_pin_rx_sync_out(po[1]), .port_pin_rx_sync_oe(pe[1]),
		.port_pin_tx_clock_in(pl[2]), .port_pin_tx_clock_out(po[2]), .port_pin_tx_clock_oe(pe[2]),
		.port_pin_tx_sync_in(pl[3]), .port_pin_tx_sync_out(po[3]), .port_pin_tx_sync_oe(pe[3]),
		.port_pin_data_a_in(pl[4]), .port_pin_data_a_out(po[4]), .port_pin_data_a_oe(pe[4]),
		.port_pin_data_b_in(pl[5]), .port_pin_data_b_out(po[5]), .port_pin_data_b_oe(pe[5]));
	eap_codec codec (.run(run), .send_a(snd_a), .send_b(snd_b), .line_a(pl[4]), .line_b(pl[5]),
		.bclk(bclk), .fsync(fsync), .sd_a(sd_a), .sd_b(sd_b), .got_a(got_a), .got_b(got_b));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [5:0] oe_exp(input logic [11:0] g);
		for (int i = 0; i < 6; i++)
			oe_exp[i] = (g[2*i+:2] == EAP_GPIO_OUT);
	endfunction
	function automatic logic [5:0] gin_exp(input logic [11:0] g, input logic [5:0] l);
		for (int i = 0; i < 6; i++)
			gin_exp[i] = (g[2*i+:2] == EAP_GPIO_IN) & l[i];
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// single ahb-lite transfer; waits as long as the slave stretches
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		{hsel, htrans} <= 3'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic report_and_stop;
		if (failures == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial
	begin
		repeat (20) @(posedge clk_sys);
		reset_n <= 1'b1;
		bus(1'b1, 8'h3C, 32'hFFFFFFFF);
		for (int a = 0; a <= 'h3C; a += 4)
		begin
			bus(1'b0, a[7:0], 32'h0);
			check(q, 32'h0);
		end
		check({26'h0, pe}, 32'h0);
		w = $random(seed);
		bus(1'b1, `EAP_OFS_RXCK, w);
		bus(1'b0, `EAP_OFS_RXCK, 32'h0);
		check(q, w & `EAP_CCR_MASK);
		repeat (6)
		begin
			w = $random(seed);
			pd <= w[21:16];
			bus(1'b1, `EAP_OFS_GDIR, w);
			bus(1'b1, `EAP_OFS_GOUT, w >> 12);
			bus(1'b0, `EAP_OFS_GIN, 32'h0);
			check(q, {26'h0, gin_exp(w[11:0], w[21:16])});
			check({20'h0, pe, po & pe}, {20'h0, oe_exp(w[11:0]), w[17:12] & oe_exp(w[11:0])});
		end
		bus(1'b1, `EAP_OFS_GDIR, 32'h0);
		bus(1'b1, `EAP_OFS_CTRL, 32'h8);
		bus(1'b1, `EAP_OFS_RXCK, 32'h103);
		bus(1'b1, `EAP_OFS_TXCK, 32'h103);
		repeat (3) @(posedge clk_sys);
		check({28'h0, pe[3:0]}, 32'hF);
		repeat (4)
		begin
			w = $random(seed) & 32'h34;
			bus(1'b1, `EAP_OFS_RXCK, 32'h3);
			bus(1'b1, `EAP_OFS_CTRL, w | 32'h109);
			repeat (300) @(posedge clk_sys);
			check({26'h0, pe[3:0], po[1:0]}, {26'h0, 4'hF, w[5], w[4]});
			bus(1'b1, `EAP_OFS_RXCK, 32'h0);
			w = $random(seed);
			pd <= w[5:0];
			repeat (300) @(posedge clk_sys);
			bus(1'b0, `EAP_OFS_STAT, 32'h0);
			check(q & 32'h3, {30'h0, w[1:0]});
		end
		bus(1'b1, `EAP_OFS_RXCK, 32'h2);
		bus(1'b1, `EAP_OFS_CTRL, 32'h10B);
		repeat (3) @(posedge clk_sys);
		check({30'h0, pe[1], po[1]}, 32'h3);
		bus(1'b1, `EAP_OFS_CTRL, 32'hB);
		repeat (3) @(posedge clk_sys);
		check({30'h0, pe[1], po[1]}, 32'h2);
		// fill while stopped, then a full fifo stalls the bus until a slot pops
		bus(1'b1, `EAP_OFS_TXCK, 32'h0);
		bus(1'b1, `EAP_OFS_RXCK, 32'h0);
		bus(1'b1, `EAP_OFS_CTRL, 32'hC9);
		w = $random(seed);
		repeat (8) bus(1'b1, `EAP_OFS_TXDATA, w);
		bus(1'b0, `EAP_OFS_STAT, 32'h0);
		check(q & 32'h4, 32'h4);
		run <= 1'b1;
		bus(1'b1, `EAP_OFS_CTRL, 32'h1C9);
		repeat (2) bus(1'b1, `EAP_OFS_TXDATA, w);
		repeat (300) @(posedge clk_sys);
		check({got_b, got_a}, w);
		check({26'h0, pe}, 32'h30);
		repeat (1600) @(posedge clk_sys);
		check({got_b, got_a}, 32'h0);
		snd_a <= 16'($random(seed));
		snd_b <= 16'($random(seed));
		bus(1'b1, `EAP_OFS_CTRL, 32'h209);
		repeat (400) @(posedge clk_sys);
		bus(1'b0, `EAP_OFS_RXDATA, 32'h0);
		check(q, {snd_b, snd_a});
		check({26'h0, pe}, 32'h0);
		report_and_stop;
	end
	initial
	begin
		#500000;
		failures++;
		report_and_stop;
	end
endmodule
